/* hw/tls_setpoints.v */
`timescale 1ns/1ps
`default_nettype none
`include "tls_consts.vh"

module tls_setpoints #(
  parameter [`TLS_MAKER_W-1:0] MAKER_CODE = 5'h0a, // arbitrary value
  parameter [`TLS_REV_W-1:0] SILICON_REVISION_CODE = 3'h1 // arbitrary value
) (
  // clock, reset, enable
  input wire clk,
  input wire reset,
  input wire clkEnable,
  // byte register port from the serial engine
  input wire ptrLoad,
  input wire [7:0] ptrData,
  input wire wrStrobe,
  input wire [7:0] wrData,
  input wire rdStrobe,
  output reg [7:0] rdData,
  output reg rdValid,
  // conversion result
  input wire tempLoad,
  input wire [15:0] tempValue,
  // configuration and status bits
  input wire alarmBehaviourSelect,
  input wire [1:0] faultQueueSetting,
  input wire alarmPolarity,
  input wire criticalPolarity,
  input wire statusRead,
  output wire [2:0] statusFlags,
  // open-drain alarm pins
  output reg alarmOut,
  output reg alarmOutEn,
  output reg criticalOut,
  output reg criticalOutEn
);

  // register pointer and the lock that drops extra written bytes
  reg [7:0] regPointer;
  reg writeLocked;
  // stored limits, upper and lower bytes
  reg [7:0] highLimitUpper;
  reg [7:0] highLimitLower;
  reg [7:0] lowLimitUpper;
  reg [7:0] lowLimitLower;
  reg [7:0] criticalLimitUpper;
  reg [7:0] criticalLimitLower;
  // hysteresis in whole degrees
  reg [`TLS_HYST_MSB:0] hysteresisValue;

  // true for the upper byte of a limit pair
  function isUpper;
    input [7:0] addr;
    begin
      isUpper = (addr == `TLS_ADDR_HIGH_UP) ||
                (addr == `TLS_ADDR_LOW_UP) ||
                (addr == `TLS_ADDR_CRIT_UP);
    end
  endfunction

  // read multiplexer by pointer value
  function [7:0] readMux;
    input [7:0] addr;
    begin
      if (addr == `TLS_ADDR_HIGH_UP)
      begin
        readMux = highLimitUpper;
      end
      else if (addr == `TLS_ADDR_HIGH_LO)
      begin
        readMux = highLimitLower;
      end
      else if (addr == `TLS_ADDR_LOW_UP)
      begin
        readMux = lowLimitUpper;
      end
      else if (addr == `TLS_ADDR_LOW_LO)
      begin
        readMux = lowLimitLower;
      end
      else if (addr == `TLS_ADDR_CRIT_UP)
      begin
        readMux = criticalLimitUpper;
      end
      else if (addr == `TLS_ADDR_CRIT_LO)
      begin
        readMux = criticalLimitLower;
      end
      else if (addr == `TLS_ADDR_HYST)
      begin
        // unused top bits read back zero
        readMux = {`TLS_HYST_UNUSED, hysteresisValue};
      end
      else if (addr == `TLS_ADDR_IDENT)
      begin
        // fixed value, never written
        readMux = {MAKER_CODE, SILICON_REVISION_CODE};
      end
      else
      begin
        // unmapped address answers zero
        readMux = `TLS_ZERO_BYTE;
      end
    end
  endfunction

  // pointer, writes and reads share one process so the
  // pointer has a single owner
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      regPointer <= `TLS_RST_PTR;
      writeLocked <= 1'b0;
      rdData <= `TLS_ZERO_BYTE;
      rdValid <= 1'b0;
      highLimitUpper <= `TLS_RST_HIGH_UP;
      highLimitLower <= `TLS_RST_HIGH_LO;
      lowLimitUpper <= `TLS_RST_LOW_UP;
      lowLimitLower <= `TLS_RST_LOW_LO;
      criticalLimitUpper <= `TLS_RST_CRIT_UP;
      criticalLimitLower <= `TLS_RST_CRIT_LO;
      hysteresisValue <= `TLS_RST_HYST;
    end
    else if (clkEnable)
    begin
      // read answer lasts one cycle
      rdValid <= 1'b0;
      if (ptrLoad)
      begin
        // new pointer reopens writing
        regPointer <= ptrData;
        writeLocked <= 1'b0;
      end
      else if (wrStrobe)
      begin
        if (!writeLocked)
        begin
          // address decode for stores
          if (regPointer == `TLS_ADDR_HIGH_UP)
          begin
            highLimitUpper <= wrData;
          end
          else if (regPointer == `TLS_ADDR_HIGH_LO)
          begin
            highLimitLower <= wrData;
          end
          else if (regPointer == `TLS_ADDR_LOW_UP)
          begin
            lowLimitUpper <= wrData;
          end
          else if (regPointer == `TLS_ADDR_LOW_LO)
          begin
            lowLimitLower <= wrData;
          end
          else if (regPointer == `TLS_ADDR_CRIT_UP)
          begin
            criticalLimitUpper <= wrData;
          end
          else if (regPointer == `TLS_ADDR_CRIT_LO)
          begin
            criticalLimitLower <= wrData;
          end
          else if (regPointer == `TLS_ADDR_HYST)
          begin
            // only the low four bits are kept
            hysteresisValue <= wrData[`TLS_HYST_MSB:0];
          end
          // upper byte steps to its lower byte, else lock
          if (isUpper(regPointer))
          begin
            regPointer <= regPointer + 8'h01;
          end
          else
          begin
            writeLocked <= 1'b1;
          end
        end
      end
      else if (rdStrobe)
      begin
        // upper byte first, then pointer moves to lower
        rdData <= readMux(regPointer);
        rdValid <= 1'b1;
        if (isUpper(regPointer))
        begin
          regPointer <= regPointer + 8'h01;
        end
      end
    end
  end

  // signed views, one bit wider to keep the hysteresis sum exact
  wire [16:0] tempExt = {tempValue[15], tempValue};
  wire [16:0] highExt = {highLimitUpper[7], highLimitUpper, highLimitLower};
  wire [16:0] lowExt = {lowLimitUpper[7], lowLimitUpper, lowLimitLower};
  wire [16:0] critExt = {criticalLimitUpper[7], criticalLimitUpper, criticalLimitLower};
  // hysteresis scaled from degrees to result counts
  wire [16:0] hystExt = {{`TLS_HYST_PAD{1'b0}}, hysteresisValue, {`TLS_HYST_SHIFT{1'b0}}};
  // thresholds at which a condition ends
  wire [16:0] highEnd = highExt - hystExt;
  wire [16:0] lowEnd = lowExt + hystExt;
  wire [16:0] critEnd = critExt - hystExt;

  // limit faults on the present result
  wire [`TLS_COND_N-1:0] faultNow;
  assign faultNow[`TLS_COND_HIGH] = $signed(tempExt) > $signed(highExt);
  assign faultNow[`TLS_COND_LOW] = $signed(tempExt) < $signed(lowExt);
  assign faultNow[`TLS_COND_CRIT] = $signed(tempExt) > $signed(critExt);
  // return past the hysteresis-adjusted limit
  wire [`TLS_COND_N-1:0] endNow;
  assign endNow[`TLS_COND_HIGH] = $signed(tempExt) < $signed(highEnd);
  assign endNow[`TLS_COND_LOW] = $signed(tempExt) > $signed(lowEnd);
  assign endNow[`TLS_COND_CRIT] = $signed(tempExt) < $signed(critEnd);

  // per-condition pin request, chosen by the mode bit
  wire [`TLS_COND_N-1:0] pinRequest;

  // one tracker per condition: fault queue, active state,
  // sticky status flag and event latch
  genvar i;
  generate
    for (i = 0; i < `TLS_COND_N; i = i + 1)
    begin : gCond
      reg [`TLS_FQ_W-1:0] faultCount; // consecutive faults so far
      reg active; // condition present, hysteresis applied
      reg flag; // sticky status bit
      reg eventPending; // event-mode latch
      // queue full on this result
      wire trip = tempLoad && faultNow[i] && (faultCount == faultQueueSetting);
      // condition ends on this result
      wire condEnd = tempLoad && active && endNow[i];

      // queue count advances on faults until full, holds on a trip, restarts otherwise
      always @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          faultCount <= `TLS_FQ_ZERO;
          active <= 1'b0;
        end
        else if (clkEnable && tempLoad)
        begin
          if (!faultNow[i])
          begin
            // broken run restarts the queue
            faultCount <= `TLS_FQ_ZERO;
          end
          else if (!trip)
          begin
            faultCount <= faultCount + `TLS_FQ_ONE;
          end
          if (trip)
          begin
            active <= 1'b1;
          end
          else if (condEnd)
          begin
            active <= 1'b0;
          end
        end
      end

      // sticky flag and event latch; a set beats a clear
      always @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          flag <= 1'b0;
          eventPending <= 1'b0;
        end
        else if (clkEnable)
        begin
          if (trip)
          begin
            flag <= 1'b1;
          end
          else if (statusRead || condEnd)
          begin
            flag <= 1'b0;
          end
          if (trip && !active)
          begin
            // new event latches until status is read
            eventPending <= 1'b1;
          end
          else if (statusRead)
          begin
            eventPending <= 1'b0;
          end
        end
      end

      assign statusFlags[i] = flag;
      // comparator follows the state, event mode the latch
      assign pinRequest[i] = alarmBehaviourSelect ? active : eventPending;
    end
  endgenerate

  // general alarm: high or low; critical pin: critical only
  wire alarmAsserted = pinRequest[`TLS_COND_HIGH] | pinRequest[`TLS_COND_LOW];
  wire criticalAsserted = pinRequest[`TLS_COND_CRIT];

  // open-drain drivers: pull low when the pin's level must be low
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      alarmOut <= 1'b0;
      alarmOutEn <= 1'b0;
      criticalOut <= 1'b0;
      criticalOutEn <= 1'b0;
    end
    else if (clkEnable)
    begin
      // pin value is always low, only the enable moves
      alarmOut <= 1'b0;
      criticalOut <= 1'b0;
      alarmOutEn <= alarmAsserted ^ alarmPolarity;
      criticalOutEn <= criticalAsserted ^ criticalPolarity;
    end
  end

endmodule
`default_nettype wire

/* inc/tls_consts.vh */
`ifndef TLS_CONSTS_VH
`define TLS_CONSTS_VH
// register addresses as seen through the pointer
`define TLS_ADDR_HIGH_UP 8'h04
`define TLS_ADDR_HIGH_LO 8'h05
`define TLS_ADDR_LOW_UP 8'h06
`define TLS_ADDR_LOW_LO 8'h07
`define TLS_ADDR_CRIT_UP 8'h08
`define TLS_ADDR_CRIT_LO 8'h09
`define TLS_ADDR_HYST 8'h0a
`define TLS_ADDR_IDENT 8'h0b
// power-up values
`define TLS_RST_HIGH_UP 8'h20
`define TLS_RST_HIGH_LO 8'h00
`define TLS_RST_LOW_UP 8'h05
`define TLS_RST_LOW_LO 8'h00
`define TLS_RST_CRIT_UP 8'h49
`define TLS_RST_CRIT_LO 8'h80
`define TLS_RST_HYST 4'h5
`define TLS_RST_PTR 8'h00
`define TLS_ZERO_BYTE 8'h00
// hysteresis field: low four bits, unused bits read zero
`define TLS_HYST_MSB 3
`define TLS_HYST_UNUSED 4'h0
// one degree is 2^7 counts of the 16-bit result
`define TLS_HYST_SHIFT 7
`define TLS_HYST_PAD 6
// identification fields
`define TLS_MAKER_W 5
`define TLS_REV_W 3
// condition indices
`define TLS_COND_HIGH 0
`define TLS_COND_LOW 1
`define TLS_COND_CRIT 2
`define TLS_COND_N 3
// fault queue counter
`define TLS_FQ_W 2
`define TLS_FQ_ZERO 2'h0
`define TLS_FQ_ONE 2'h1
`endif

/* verification/tls_setpoints_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// port checks of the limit register block
module tls_setpoints_sva (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEnable,
  // register port
  input wire logic ptrLoad,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [7:0] rdData,
  input wire logic rdValid,
  // conversion and alarms
  input wire logic tempLoad,
  input wire logic alarmBehaviourSelect,
  input wire logic alarmPolarity,
  input wire logic criticalPolarity,
  input wire logic statusRead,
  input wire logic [2:0] statusFlags,
  input wire logic alarmOutEn,
  input wire logic criticalOutEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // a taken read answers next cycle
  property p_rdAnswer;
    clkEnable && rdStrobe && !ptrLoad && !wrStrobe |=> rdValid;
  endproperty
  a_rdAnswer: assert property (p_rdAnswer) else $error("read not answered");
  // no answer without a taken read; a frozen cycle keeps the old answer
  property p_rdCause;
    rdValid |-> ($past(clkEnable) ? $past(rdStrobe && !ptrLoad && !wrStrobe) : $past(rdValid));
  endproperty
  a_rdCause: assert property (p_rdCause) else $error("stray read answer");
  // read byte holds between answers
  property p_rdHold;
    !rdValid |-> $stable(rdData);
  endproperty
  a_rdHold: assert property (p_rdHold) else $error("read byte moved");
  // status read alone empties the flags
  property p_statusClear;
    clkEnable && statusRead && !tempLoad |=> statusFlags == 3'h0;
  endproperty
  a_statusClear: assert property (p_statusClear) else $error("flags kept");
  // flags only rise after a new result
  property p_flagCause;
    (statusFlags & ~$past(statusFlags)) != 3'h0 |-> $past(tempLoad && clkEnable);
  endproperty
  a_flagCause: assert property (p_flagCause) else $error("flag without result");
  // critical trip pulls the critical pin
  property p_critPin;
    $rose(statusFlags[2]) && alarmBehaviourSelect && !criticalPolarity |=> criticalOutEn;
  endproperty
  a_critPin: assert property (p_critPin) else $error("critical pin idle");
  // over-limit trip pulls the general pin
  property p_highPin;
    $rose(statusFlags[0]) && alarmBehaviourSelect && !alarmPolarity |=> alarmOutEn;
  endproperty
  a_highPin: assert property (p_highPin) else $error("alarm pin idle on high");
  // under-limit trip pulls the general pin
  property p_lowPin;
    $rose(statusFlags[1]) && alarmBehaviourSelect && !alarmPolarity |=> alarmOutEn;
  endproperty
  a_lowPin: assert property (p_lowPin) else $error("alarm pin idle on low");
  // main scenarios reached
  c_read: cover property (rdValid);
  c_crit: cover property (statusFlags[2] && criticalOutEn);
  c_event: cover property (alarmOutEn && !alarmBehaviourSelect);
endmodule
bind tls_setpoints tls_setpoints_sva u_tls_setpoints_sva (.clk(clk), .reset(reset), .clkEnable(clkEnable),
  .ptrLoad(ptrLoad), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .rdValid(rdValid),
  .tempLoad(tempLoad), .alarmBehaviourSelect(alarmBehaviourSelect), .alarmPolarity(alarmPolarity),
  .criticalPolarity(criticalPolarity), .statusRead(statusRead), .statusFlags(statusFlags),
  .alarmOutEn(alarmOutEn), .criticalOutEn(criticalOutEn));
`default_nettype wire

/* verification/tls_host.sv */
`timescale 1ns/1ps
`default_nettype none
// serial engine side: loads the pointer, moves single bytes
module tls_host (
  // clock
  input wire logic clk,
  // register port
  output var logic ptrLoad,
  output var logic [7:0] ptrData,
  output var logic wrStrobe,
  output var logic [7:0] wrData,
  output var logic rdStrobe
);
  // idle port at time zero
  initial
  begin
    ptrLoad = 1'b0;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    ptrData = 8'h00;
    wrData = 8'h00;
  end
  // kind 0 pointer, 1 write, 2 read; pairs are reached by upper address only
  task acc(input logic [1:0] k, input logic [7:0] v);
    @(posedge clk);
    ptrLoad <= k == 2'h0;
    wrStrobe <= k == 2'h1;
    rdStrobe <= k == 2'h2;
    ptrData <= v;
    wrData <= v;
    @(posedge clk);
    ptrLoad <= 1'b0;
    wrStrobe <= 1'b0;
    rdStrobe <= 1'b0;
    // released lines never keep the last value
    ptrData <= ~v;
    wrData <= ~v;
  endtask
endmodule
`default_nettype wire

/* verification/tls_setpoints_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tls_setpoints_tb;
  // block inputs and outputs
  logic clk, reset, clkEnable, tempLoad, statusRead, rdValid, alarmOut, alarmOutEn, criticalOut, criticalOutEn;
  logic alarmBehaviourSelect, alarmPolarity, criticalPolarity, ptrLoad, wrStrobe, rdStrobe;
  logic [7:0] ptrData, wrData, rdData;
  logic [15:0] tempValue;
  logic [1:0] faultQueueSetting;
  logic [2:0] statusFlags;
  // tallies, random state, expected read bytes
  int miscompares = 0, samplesChecked = 0, q;
  logic [31:0] seed = 32'h11, r;
  logic [7:0] expQ[$];
  tls_setpoints u_tls_setpoints (
    .clk(clk), .reset(reset), .clkEnable(clkEnable),
    .ptrLoad(ptrLoad), .ptrData(ptrData), .wrStrobe(wrStrobe), .wrData(wrData), .rdStrobe(rdStrobe),
    .rdData(rdData), .rdValid(rdValid), .tempLoad(tempLoad), .tempValue(tempValue),
    .alarmBehaviourSelect(alarmBehaviourSelect), .faultQueueSetting(faultQueueSetting),
    .alarmPolarity(alarmPolarity), .criticalPolarity(criticalPolarity), .statusRead(statusRead),
    .statusFlags(statusFlags), .alarmOut(alarmOut), .alarmOutEn(alarmOutEn), .criticalOut(criticalOut),
    .criticalOutEn(criticalOutEn)
  );
  tls_host u_tls_host (
    .clk(clk), .ptrLoad(ptrLoad), .ptrData(ptrData), .wrStrobe(wrStrobe), .wrData(wrData),
    .rdStrobe(rdStrobe)
  );
  // clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // one comparison
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    samplesChecked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // note the expected byte, then read
  task rd(input logic [7:0] e);
    expQ.push_back(e);
    u_tls_host.acc(2'h2, 8'h00);
  endtask
  // point, read two bytes
  task rp(input logic [7:0] a, input logic [7:0] u, input logic [7:0] l);
    u_tls_host.acc(2'h0, a);
    rd(u);
    rd(l);
  endtask
  // point, write three bytes
  task wp(input logic [7:0] a, input logic [7:0] u, input logic [7:0] l, input logic [7:0] x);
    u_tls_host.acc(2'h0, a);
    u_tls_host.acc(2'h1, u);
    u_tls_host.acc(2'h1, l);
    u_tls_host.acc(2'h1, x);
  endtask
  // new result (s=0) or status read (s=1); flags next cycle, pins one later
  task ev(input logic s, input logic [15:0] t, input logic [2:0] f, input logic a, input logic c);
    @(posedge clk);
    tempLoad <= !s;
    statusRead <= s;
    tempValue <= t;
    @(posedge clk);
    tempLoad <= 1'b0;
    statusRead <= 1'b0;
    @(negedge clk);
    cmp({5'h00, statusFlags}, {5'h00, f});
    @(negedge clk);
    cmp({6'h00, alarmOutEn, criticalOutEn}, {6'h00, a, c});
    // open-drain data lines never leave low
    cmp({6'h00, alarmOut, criticalOut}, 8'h00);
  endtask
  // verdict
  task summarize;
    $display("checks %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // each read answer meets the oldest note
  always @(negedge clk)
    if (rdValid === 1'b1)
      cmp(rdData, expQ.size() > 0 ? expQ.pop_front() : 8'hxx);
  // hang guard
  initial
  begin
    #40000;
    miscompares++;
    summarize();
  end
  // main sequence
  initial
  begin
    reset = 1'b1;
    clkEnable = 1'b1;
    tempLoad = 1'b0;
    statusRead = 1'b0;
    tempValue = 16'h0000;
    alarmBehaviourSelect = 1'b1;
    faultQueueSetting = 2'h0;
    alarmPolarity = 1'b0;
    criticalPolarity = 1'b0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rp(8'h04, 8'h20, 8'h00);
    rp(8'h06, 8'h05, 8'h00);
    rp(8'h08, 8'h49, 8'h80);
    rp(8'h0a, 8'h05, 8'h05);
    rp(8'h0b, 8'h51, 8'h51);
    rp(8'h0c, 8'h00, 8'h00);
    $display("test power-up values done");
    // random bytes through all three limit pairs; the third byte must be dropped
    for (q = 0; q < 6; q++)
    begin
      r = rnd();
      wp(8'h04 + 8'(2 * (q % 3)), r[15:8], r[7:0], r[23:16]);
      rp(8'h04 + 8'(2 * (q % 3)), r[15:8], r[7:0]);
    end
    wp(8'h0a, 8'hff, 8'h00, 8'h00);
    rp(8'h0a, 8'h0f, 8'h0f);
    wp(8'h0b, 8'h00, 8'h00, 8'h00);
    rp(8'h0b, 8'h51, 8'h51);
    // reset in mid-run brings every written value back
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rp(8'h04, 8'h20, 8'h00);
    rp(8'h06, 8'h05, 8'h00);
    rp(8'h08, 8'h49, 8'h80);
    rp(8'h0a, 8'h05, 8'h05);
    wp(8'h0a, 8'h05, 8'h00, 8'h00);
    wp(8'h08, 8'h30, 8'h00, 8'hff);
    $display("test writes done");
    ev(0, 16'h1000, 3'h0, 0, 0);
    ev(0, 16'h2100, 3'h1, 1, 0);
    ev(0, 16'h1e00, 3'h1, 1, 0);
    ev(0, 16'h1d00, 3'h0, 0, 0);
    ev(0, 16'h3100, 3'h5, 1, 1);
    ev(0, 16'h0400, 3'h2, 1, 0);
    ev(0, 16'hff00, 3'h2, 1, 0);
    ev(0, 16'h2100, 3'h1, 1, 0);
    ev(1, 16'h2100, 3'h0, 1, 0);
    ev(0, 16'h1000, 3'h0, 0, 0);
    @(posedge clk);
    alarmBehaviourSelect <= 1'b0;
    ev(0, 16'h2100, 3'h1, 1, 0);
    ev(0, 16'h1000, 3'h0, 1, 0);
    ev(1, 16'h1000, 3'h0, 0, 0);
    @(posedge clk);
    alarmBehaviourSelect <= 1'b1;
    for (q = 1; q < 4; q++)
    begin
      @(posedge clk);
      faultQueueSetting <= q[1:0];
      repeat (q) ev(0, 16'h2100, 3'h0, 0, 0);
      ev(0, 16'h2100, 3'h1, 1, 0);
      ev(0, 16'h1000, 3'h0, 0, 0);
    end
    @(posedge clk);
    faultQueueSetting <= 2'h0;
    alarmPolarity <= 1'b1;
    criticalPolarity <= 1'b1;
    ev(0, 16'h1000, 3'h0, 1, 1);
    ev(0, 16'h2100, 3'h1, 0, 1);
    // clock enable low: a status read is ignored, flags and pins hold
    @(posedge clk);
    clkEnable <= 1'b0;
    ev(1, 16'h1000, 3'h1, 0, 1);
    @(posedge clk);
    clkEnable <= 1'b1;
    $display("test alarms done");
    repeat (4) @(posedge clk);
    cmp(8'(expQ.size()), 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
